// ===== hw/wold_defines.svh
// Constants of the wake-on-LAN detection and status block.
// Assumes inclusion by bare name from the files under hw/.
// Summary of operation
// - Reorder each received byte per the two-bit swap code before any matching.
// - Hunt for start delimiter 0xD5, or 0x5D when delimiter select is set.
// - With CRC gate set, bad-CRC frames give no magic or pattern indication.
// - With CRC gate cleared, a bad-CRC frame gives no indication at all.
// - Writing the self-clearing clear bit drops the held level indication.
// - Pulse mode drives the wake pulse for 8, 16, 32 or 64 fast cycles.
// - Indication select 1 gives a held level, 0 a timed pulse.
// - Wake detection runs only while wake enable is 1.
// - Password enable makes a magic packet valid only with matching password.
// - Pattern enable raises wake interrupt on a packet holding the pattern.
// - Magic enable raises wake interrupt on a valid magic packet.
// - Source select routes wake (1) or polarity (0) interrupt to bit 1.
// - Enabling wake detection sets the interrupt source select automatically.
// - Sticky clear-on-read flag for a frame lacking the selected delimiter.
// - Sticky clear-on-read flag for a received frame with a bad CRC, only while the CRC gate is set.
// - Sticky clear-on-read intrusion flag for a magic packet with bad password.
// - Sticky clear-on-read flag for a valid packet with the configured pattern.
// - Sticky clear-on-read flag for a valid magic packet.
// - Magic packets are compared against the six-byte destination address.
// - Password bytes come from the password input, byte 0 received first.
`ifndef WOLD_DEFINES_SVH
`define WOLD_DEFINES_SVH

`define WOLD_IDX_CFG      30'h0000_04a0
`define WOLD_IDX_STAT     30'h0000_04a1
`define WOLD_REG_W        16
`define WOLD_CFG_RST      16'h1000
`define WOLD_HSIZE_WORD   3'h2
`define WOLD_SWAP_NONE    2'h0
`define WOLD_SWAP_BITS    2'h1
`define WOLD_SWAP_NIB     2'h2
`define WOLD_SWAP_NIBBITS 2'h3
`define WOLD_SFD_STD      8'hd5
`define WOLD_SFD_ALT      8'h5d
`define WOLD_SYNC_BYTE    8'hff
`define WOLD_SYNC_LEN     3'h6
`define WOLD_DA_LAST      3'h5
`define WOLD_COPY_LAST    4'hf
`define WOLD_PW_LEN       3'h6
`define WOLD_CRC_INIT     32'hffff_ffff
`define WOLD_CRC_POLY     32'hedb8_8320
`define WOLD_CRC_RESIDUE  32'hdebb_20e3
`define WOLD_PULSE_BASE   8
`define WOLD_IND_CLK_MHZ  100
`define WOLD_HCLK_MHZ     40

`endif

// ===== hw/wold_pkg.sv
// Types shared by the wake-on-LAN detection block.
// Assumes the constants header is compiled alongside.
package wold_pkg;

  typedef struct packed {
    logic [1:0] swap;
    logic       sfd_alt;
    logic       crc_gate;
    logic       lvl_clr;
    logic [1:0] pulse_sel;
    logic       lvl_mode;
    logic       wake_en;
    logic       bit_mask;
    logic       pw_en;
    logic [2:0] rsvd;
    logic       pat_en;
    logic       magic_en;
  } wold_cfg_t;

  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic       int_src;
    logic [3:0] rsvd_mid;
    logic       sfd_err;
    logic       bad_crc;
    logic       hack;
    logic [2:0] rsvd_lo;
    logic       pattern;
    logic       magic;
  } wold_stat_t;

  typedef struct packed {
    logic       dv;
    logic       valid;
    logic [7:0] data;
  } wold_rx_t;

  typedef enum logic [1:0] {F_IDLE, F_HUNT, F_BODY} wold_fst_t;

endpackage : wold_pkg

// ===== hw/wold_crc32.sv
// Byte-wide running CRC-32 over received frame bytes, LSB first.
// Assumes init and en are never asserted in the same cycle.
`timescale 1ns/100ps
`include "wold_defines.svh"
module wold_crc32 (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc
);

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `WOLD_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      crc <= `WOLD_CRC_INIT;
    else if (init)
      crc <= `WOLD_CRC_INIT;
    else if (en)
      crc <= crc_step(crc, data);

endmodule : wold_crc32

// ===== hw/wold_wake_ind.sv
// Wake indication output: timed pulse or held level.
// Assumes evt is a one-cycle pulse on hclk.
`timescale 1ns/100ps
`include "wold_defines.svh"
module wold_wake_ind #(
  parameter int IND_MHZ  = `WOLD_IND_CLK_MHZ,
  parameter int HCLK_MHZ = `WOLD_HCLK_MHZ
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       evt,
  input  wire logic       level_mode,
  input  wire logic [1:0] pulse_sel,
  input  wire logic       lvl_clr,
  output logic            wake_out
);

  // Bus-clock counts rounded up so the pulse is never shorter than asked
  function automatic logic [7:0] pulse_len(input logic [1:0] sel);
    int t;
    t = ((`WOLD_PULSE_BASE << sel) * HCLK_MHZ + IND_MHZ - 1) / IND_MHZ;
    return t[7:0];
  endfunction : pulse_len

  logic [7:0] cnt_r;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt_r    <= 8'h00;
      wake_out <= 1'b0;
    end
    else if (level_mode)
    begin
      cnt_r    <= 8'h00;
      wake_out <= evt | (wake_out & ~lvl_clr);
    end
    else if (evt)
    begin
      cnt_r    <= pulse_len(pulse_sel) - 8'h01;
      wake_out <= 1'b1;
    end
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
    else
      wake_out <= 1'b0;

endmodule : wold_wake_ind

// ===== hw/wold_top.sv
// Wake-on-LAN detection and status block with an AHB-Lite register slave.
// Assumes the receive byte stream and interrupt inputs are on hclk.
`timescale 1ns/100ps
`include "wold_defines.svh"
module wold_top #(
  parameter int IND_MHZ  = `WOLD_IND_CLK_MHZ,
  parameter int HCLK_MHZ = `WOLD_HCLK_MHZ
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  input  wire wold_pkg::wold_rx_t rx,
  input  wire logic [47:0]      dest_addr,
  input  wire logic [47:0]      password,
  input  wire logic             pattern_hit,
  input  wire logic             data_pol_irq,
  output logic                  wake_pin,
  output logic                  int_bit1
);

  wold_pkg::wold_cfg_t  cfg_r;
  wold_pkg::wold_cfg_t  cfg_nxt;
  wold_pkg::wold_cfg_t  wcfg;
  wold_pkg::wold_stat_t wstat;
  wold_pkg::wold_stat_t stat_r;
  wold_pkg::wold_stat_t stat_view;
  wold_pkg::wold_fst_t  st_r;

  logic        int_src_r;
  logic        int_src_nxt;
  logic        wr_pend_r;
  logic [29:0] wr_idx_r;
  logic        acc;
  logic        cfg_wr;
  logic        stat_wr;
  logic        rd_stat;
  logic        lvl_clr_r;
  logic [31:0] rd_val;

  logic [7:0]  rb;
  logic [7:0]  sfd_code;
  logic        bv;
  logic        dv_r;
  logic        frame_end;
  logic        sfd_hit;
  logic [31:0] crc;
  logic        crc_ok;

  logic [2:0]  sync_r;
  logic [2:0]  da_idx_r;
  logic [3:0]  copy_r;
  logic        magic_r;
  logic [2:0]  pw_idx_r;
  logic        pw_ok_r;
  logic        pat_r;
  logic        pw_good;

  logic        eval;
  logic        set_sfd;
  logic        set_bad;
  logic        set_magic;
  logic        set_hack;
  logic        set_pat;
  logic        wake_evt;

  function automatic logic [7:0] swap_byte(input logic [7:0] b, input logic [1:0] mode);
    logic [7:0] r;
    r = b;
    unique case (mode)
      `WOLD_SWAP_NONE:
        r = b;
      `WOLD_SWAP_BITS:
        for (int i = 0; i < 8; i++)
        begin
          r[i] = b[7-i];
        end
      `WOLD_SWAP_NIB:
        r = {b[3:0], b[7:4]};
      `WOLD_SWAP_NIBBITS:
        r = {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
    endcase
    return r;
  endfunction : swap_byte

  // Byte 0 of a six-byte field is the first one on the wire
  function automatic logic [7:0] byte_at(input logic [47:0] v, input logic [2:0] idx);
    return v[{idx, 3'h0} +: 8];
  endfunction : byte_at

  // Set wins over a clear-on-read landing in the same cycle
  function automatic logic sticky(input logic old, input logic set, input logic clr);
    return set | (old & ~clr);
  endfunction : sticky

  // Register bus decode

  assign acc     = hsel & hready & htrans[1];
  assign rd_stat = acc & ~hwrite & (haddr[31:2] == `WOLD_IDX_STAT);
  assign cfg_wr  = wr_pend_r & (wr_idx_r == `WOLD_IDX_CFG);
  assign stat_wr = wr_pend_r & (wr_idx_r == `WOLD_IDX_STAT);
  assign wcfg    = wold_pkg::wold_cfg_t'(hwdata[`WOLD_REG_W-1:0]);
  assign wstat   = wold_pkg::wold_stat_t'(hwdata[`WOLD_REG_W-1:0]);

  // Only whole-word writes are taken; narrower ones are dropped silently
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 30'h0000_0000;
    end
    else
    begin
      wr_pend_r <= acc & hwrite & (hsize == `WOLD_HSIZE_WORD);
      wr_idx_r  <= haddr[31:2];
    end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end

  // Forwarding the data-phase write keeps a back-to-back read coherent
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (cfg_wr)
      cfg_nxt = wcfg;
    cfg_nxt.lvl_clr = 1'b0;
  end

  // Auto-route wins over a status write landing in the same data phase
  always_comb
  begin
    int_src_nxt = int_src_r;
    if (cfg_wr & wcfg.wake_en & ~cfg_r.wake_en)
      int_src_nxt = 1'b1;
    else if (stat_wr)
      int_src_nxt = wstat.int_src;
  end

  // Reads see the source select as it stands after a pending write
  always_comb
  begin
    stat_view          = stat_r;
    stat_view.int_src  = int_src_nxt;
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (haddr[31:2] == `WOLD_IDX_CFG)
      rd_val[`WOLD_REG_W-1:0] = cfg_nxt;
    else if (haddr[31:2] == `WOLD_IDX_STAT)
      rd_val[`WOLD_REG_W-1:0] = stat_view;
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (acc & ~hwrite)
      hrdata <= rd_val;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cfg_r <= wold_pkg::wold_cfg_t'(`WOLD_CFG_RST);
    else
      cfg_r <= cfg_nxt;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      lvl_clr_r <= 1'b0;
    else
      lvl_clr_r <= cfg_wr & wcfg.lvl_clr;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      int_src_r <= 1'b0;
    else
      int_src_r <= int_src_nxt;

  // Receive framing

  assign rb        = swap_byte(rx.data, cfg_r.swap);
  assign sfd_code  = cfg_r.sfd_alt ? `WOLD_SFD_ALT : `WOLD_SFD_STD;
  assign bv        = rx.dv & rx.valid;
  // Verdict is taken in the first idle cycle, when the last byte is in
  assign frame_end = dv_r & ~rx.dv;
  assign sfd_hit   = bv & (st_r != wold_pkg::F_BODY) & (rb == sfd_code);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      dv_r <= 1'b0;
    else
      dv_r <= rx.dv;

  // Any byte before the delimiter counts as preamble
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      st_r <= wold_pkg::F_IDLE;
    else if (frame_end)
      st_r <= wold_pkg::F_IDLE;
    else if (sfd_hit)
      st_r <= wold_pkg::F_BODY;
    else if ((st_r == wold_pkg::F_IDLE) & rx.dv)
      st_r <= wold_pkg::F_HUNT;

  wold_crc32 u_crc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .init    (sfd_hit),
    .en      (bv & (st_r == wold_pkg::F_BODY)),
    .data    (rb),
    .crc     (crc)
  );

  // Running over data and check bytes leaves a fixed residue on a good frame
  assign crc_ok = (crc == `WOLD_CRC_RESIDUE);

  // Magic packet search; a partial match restarts from the current byte only
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      sync_r   <= 3'h0;
      da_idx_r <= 3'h0;
      copy_r   <= 4'h0;
      magic_r  <= 1'b0;
      pw_idx_r <= 3'h0;
      pw_ok_r  <= 1'b1;
    end
    else if (sfd_hit)
    begin
      sync_r   <= 3'h0;
      da_idx_r <= 3'h0;
      copy_r   <= 4'h0;
      magic_r  <= 1'b0;
      pw_idx_r <= 3'h0;
      pw_ok_r  <= 1'b1;
    end
    else if (bv & (st_r == wold_pkg::F_BODY))
    begin
      if (magic_r)
      begin
        if (pw_idx_r != `WOLD_PW_LEN)
        begin
          pw_ok_r  <= pw_ok_r & (rb == byte_at(password, pw_idx_r));
          pw_idx_r <= pw_idx_r + 3'h1;
        end
      end
      else if (sync_r != `WOLD_SYNC_LEN)
        sync_r <= (rb == `WOLD_SYNC_BYTE) ? sync_r + 3'h1 : 3'h0;
      else if (rb == byte_at(dest_addr, da_idx_r))
      begin
        if (da_idx_r == `WOLD_DA_LAST)
        begin
          da_idx_r <= 3'h0;
          if (copy_r == `WOLD_COPY_LAST)
            magic_r <= 1'b1;
          else
            copy_r <= copy_r + 4'h1;
        end
        else
          da_idx_r <= da_idx_r + 3'h1;
      end
      else if (!((rb == `WOLD_SYNC_BYTE) & (copy_r == 4'h0) & (da_idx_r == 3'h0)))
      begin
        sync_r   <= (rb == `WOLD_SYNC_BYTE) ? 3'h1 : 3'h0;
        da_idx_r <= 3'h0;
        copy_r   <= 4'h0;
      end
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      pat_r <= 1'b0;
    else if (sfd_hit)
      pat_r <= 1'b0;
    else if ((st_r == wold_pkg::F_BODY) & pattern_hit)
      pat_r <= 1'b1;

  // End-of-frame verdict

  assign pw_good   = pw_ok_r & (pw_idx_r == `WOLD_PW_LEN);
  assign eval      = frame_end & (st_r == wold_pkg::F_BODY) & cfg_r.wake_en;
  assign set_sfd   = frame_end & (st_r == wold_pkg::F_HUNT) & cfg_r.wake_en;
  // With the gate off a bad frame is simply not reported
  assign set_bad   = eval & ~crc_ok & cfg_r.crc_gate;
  assign set_magic = eval & crc_ok & magic_r & (~cfg_r.pw_en | pw_good);
  assign set_hack  = eval & crc_ok & magic_r & cfg_r.pw_en & ~pw_good;
  assign set_pat   = eval & crc_ok & pat_r;
  assign wake_evt  = (set_magic & cfg_r.magic_en) | (set_pat & cfg_r.pat_en);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      stat_r <= wold_pkg::wold_stat_t'(16'h0000);
    else
    begin
      stat_r.sfd_err <= sticky(stat_r.sfd_err, set_sfd, rd_stat);
      stat_r.bad_crc <= sticky(stat_r.bad_crc, set_bad, rd_stat);
      stat_r.hack    <= sticky(stat_r.hack, set_hack, rd_stat);
      stat_r.pattern <= sticky(stat_r.pattern, set_pat, rd_stat);
      stat_r.magic   <= sticky(stat_r.magic, set_magic, rd_stat);
    end

  // Registered so a change of source select cannot glitch the interrupt
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      int_bit1 <= 1'b0;
    else
      int_bit1 <= int_src_r ? wake_evt : data_pol_irq;

  // Pulse length is reckoned in bus cycles from the two clock rates
  wold_wake_ind #(
    .IND_MHZ  (IND_MHZ),
    .HCLK_MHZ (HCLK_MHZ)
  ) u_ind (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .evt        (wake_evt),
    .level_mode (cfg_r.lvl_mode),
    .pulse_sel  (cfg_r.pulse_sel),
    .lvl_clr    (lvl_clr_r),
    .wake_out   (wake_pin)
  );

endmodule : wold_top

// ===== testbench/wold_sva.sv
// Checker on the ports of the wake detection block.
// Assumes it is bound into wold_top; everything runs on hclk.
`timescale 1ns/100ps
`include "wold_defines.svh"
module wold_sva #(
  parameter int IND_MHZ  = `WOLD_IND_CLK_MHZ,
  parameter int HCLK_MHZ = `WOLD_HCLK_MHZ
) (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  input wire wold_pkg::wold_rx_t rx,
  input wire logic               data_pol_irq,
  input wire logic               wake_pin,
  input wire logic               int_bit1
);
  logic rd_ph;
  logic end_ph;
  assign rd_ph = hsel && hready && htrans[1] && !hwrite;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or not okay");
  a_int_cause: assert property (int_bit1 |-> $past(data_pol_irq) || end_ph)
    else $error("interrupt bit without cause");
  a_wake_cause: assert property ($rose(wake_pin) |-> end_ph)
    else $error("wake rose outside frame end");
  a_wake_min: assert property ($rose(wake_pin) |-> wake_pin [*4])
    else $error("wake shorter than four cycles");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_unmapped_zero: assert property (rd_ph && haddr[31:2] != `WOLD_IDX_CFG
    && haddr[31:2] != `WOLD_IDX_STAT |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_clr_reads0: assert property (rd_ph && haddr[31:2] == `WOLD_IDX_CFG |=> !hrdata[11])
    else $error("clear bit read back set");
  a_stat_rsvd: assert property (rd_ph && haddr[31:2] == `WOLD_IDX_STAT
    |=> hrdata[15:13] == 3'h0 && hrdata[11:8] == 4'h0 && hrdata[4:2] == 3'h0)
    else $error("status reserved bits set");
  a_rd_hold: assert property (!$past(rd_ph) |-> $stable(hrdata))
    else $error("read data moved without read");
  // Frame end seen one edge late, so rise tests need no extra depth
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      end_ph <= 1'b0;
    else
      end_ph <= $past(rx.dv) && !rx.dv;
endmodule : wold_sva
bind wold_top wold_sva #(.IND_MHZ(IND_MHZ), .HCLK_MHZ(HCLK_MHZ)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .rx(rx), .data_pol_irq(data_pol_irq), .wake_pin(wake_pin),
  .int_bit1(int_bit1));

// ===== testbench/wold_link_partner.sv
// Link partner model sending frames on the receive byte stream.
// Assumes the bench calls send right after a rising edge of hclk.
`timescale 1ns/100ps
`include "wold_defines.svh"
module wold_link_partner (
  input  wire logic          hclk,
  output wold_pkg::wold_rx_t rx,
  output logic               pattern_hit
);
  logic busy;
  initial
  begin
    rx = '0;
    pattern_hit = 1'h0;
    busy = 1'h0;
  end
  // Idle data toggles so a stale byte can never pass as a real one
  always @(posedge hclk)
    if (!busy)
      rx.data <= ~rx.data;
  function automatic logic [7:0] wire_byte(input logic [1:0] sw, input logic [7:0] b);
    case (sw)
      2'h1: return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
      2'h2: return {b[3:0], b[7:4]};
      2'h3: return {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
      default: return b;
    endcase
  endfunction : wire_byte
  task automatic put(input logic [7:0] b, input logic hit, input int gap);
    rx <= {2'h3, b};
    pattern_hit <= hit;
    @(posedge hclk);
    repeat (gap)
    begin
      rx <= {2'h2, ~b};
      pattern_hit <= 1'h0;
      @(posedge hclk);
    end
  endtask : put
  // f: [3] alternate delimiter, [2] no delimiter, [1] bad FCS, [0] pattern hit
  task automatic send(input logic [1:0] sw, input logic [3:0] f,
                      input logic [47:0] da, pw, input int gap);
    logic [7:0]  q[$];
    logic [31:0] crc;
    q = {};
    repeat (6) q.push_back(`WOLD_SYNC_BYTE);
    repeat (16) for (int k = 0; k < 6; k++) q.push_back(da[8*k+:8]);
    for (int k = 0; k < 6; k++) q.push_back(pw[8*k+:8]);
    crc = `WOLD_CRC_INIT;
    foreach (q[k])
    begin
      crc ^= {24'h00_0000, q[k]};
      repeat (8) crc = crc[0] ? (crc >> 1) ^ `WOLD_CRC_POLY : crc >> 1;
    end
    crc = ~crc ^ {31'h0, f[1]};
    for (int k = 0; k < 4; k++) q.push_back(crc[8*k+:8]);
    busy = 1'h1;
    repeat (7) put(wire_byte(sw, 8'h55), 1'h0, gap);
    if (!f[2])
    begin
      put(wire_byte(sw, f[3] ? `WOLD_SFD_ALT : `WOLD_SFD_STD), 1'h0, gap);
      foreach (q[k]) put(wire_byte(sw, q[k]), f[0] && k == 30, gap);
    end
    rx <= {2'h0, 8'ha5};
    pattern_hit <= 1'h0;
    @(posedge hclk);
    busy = 1'h0;
  endtask : send
endmodule : wold_link_partner

// ===== testbench/wold_top_tb.sv
// Self-checking bench: AHB-Lite register access plus frames from the partner.
// Assumes hready is fed back from the single slave's hreadyout.
`timescale 1ns/100ps
`include "wold_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module wold_top_tb;
  localparam logic [31:0] A_CFG  = {`WOLD_IDX_CFG, 2'h0};
  localparam logic [31:0] A_STAT = {`WOLD_IDX_STAT, 2'h0};
  localparam logic [47:0] DA     = 48'h6655_4433_2211;
  localparam logic [47:0] PW     = 48'hc6c5_c4c3_c2c1;
  logic               hclk = 1'h0;
  logic               hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [47:0]        dest_addr, password;
  logic               pattern_hit, data_pol_irq, wake_pin, int_bit1;
  wold_pkg::wold_rx_t rx;
  int                 errors, check_count, cyc, nw, ni;
  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;
  wold_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx(rx), .dest_addr(dest_addr),
    .password(password), .pattern_hit(pattern_hit), .data_pol_irq(data_pol_irq),
    .wake_pin(wake_pin), .int_bit1(int_bit1));
  wold_link_partner u_lp (.hclk(hclk), .rx(rx), .pattern_hit(pattern_hit));
  task automatic give_verdict();
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic ahb(input logic wr, input logic [31:0] a, wd);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [31:0] a, d);
    ahb(1'h1, a, d);
  endtask : wr
  task automatic rchk(input logic [31:0] a, e);
    ahb(1'h0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask : rchk
  // Counts high cycles of both indications over a fixed window after frame end
  task automatic frame(input logic [1:0] sw, input logic [3:0] f, input logic [47:0] da, pw,
                       input int gap, ew, ei);
    u_lp.send(sw, f, da, pw, gap);
    nw = 0;
    ni = 0;
    repeat (100)
    begin
      @(posedge hclk);
      nw += (wake_pin === 1'h1);
      ni += (int_bit1 === 1'h1);
    end
    `CHK(nw, ew)
    `CHK(ni, ei)
  endtask : frame
  function automatic int wid(input int sel);
    return ((`WOLD_PULSE_BASE << sel) * `WOLD_HCLK_MHZ + `WOLD_IND_CLK_MHZ - 1)
           / `WOLD_IND_CLK_MHZ;
  endfunction : wid
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      give_verdict();
    end
  end
  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, data_pol_irq} = '0;
    hsize = `WOLD_HSIZE_WORD;
    dest_addr = DA;
    password = PW;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    rchk(A_CFG, 32'h0000_1000);
    rchk(A_STAT, 32'h0000_0000);
    wr(32'h0000_0100, 32'h0000_ffff);
    rchk(32'h0000_0100, 32'h0000_0000);
    hsize <= 3'h1;
    wr(A_CFG, 32'h0000_00ff);
    hsize <= `WOLD_HSIZE_WORD;
    rchk(A_CFG, 32'h0000_1000);
    wr(A_CFG, 32'h0000_1083);
    rchk(A_STAT, 32'h0000_1000);
    for (int i = 0; i < 4; i++)
    begin
      wr(A_CFG, 32'h0000_1083 | (i << 14) | ((i % 2) << 13) | (i << 9));
      frame(i[1:0], {i[0], 3'h0}, DA, PW, i / 2, wid(i), 1);
      rchk(A_STAT, 32'h0000_1001);
    end
    wr(A_CFG, 32'h0000_1083);
    frame(2'h0, 4'h4, DA, PW, 0, 0, 0);
    rchk(A_STAT, 32'h0000_1080);
    rchk(A_STAT, 32'h0000_1000);
    frame(2'h0, 4'h2, DA, PW, 0, 0, 0);
    rchk(A_STAT, 32'h0000_1040);
    wr(A_CFG, 32'h0000_0083);
    frame(2'h0, 4'h2, DA, PW, 0, 0, 0);
    rchk(A_STAT, 32'h0000_1000);
    wr(A_CFG, 32'h0000_1082);
    frame(2'h0, 4'h1, ~DA, PW, 0, wid(0), 1);
    rchk(A_STAT, 32'h0000_1002);
    wr(A_CFG, 32'h0000_10a1);
    frame(2'h0, 4'h0, DA, ~PW, 0, 0, 0);
    rchk(A_STAT, 32'h0000_1020);
    frame(2'h0, 4'h0, DA, PW, 0, wid(0), 1);
    rchk(A_STAT, 32'h0000_1001);
    wr(A_CFG, 32'h0000_1003);
    frame(2'h0, 4'h0, DA, PW, 0, 0, 0);
    rchk(A_STAT, 32'h0000_1000);
    wr(A_CFG, 32'h0000_1183);
    frame(2'h0, 4'h0, DA, PW, 0, 100, 1);
    wr(A_CFG, 32'h0000_1983);
    rchk(A_CFG, 32'h0000_1183);
    repeat (2) @(posedge hclk);
    `CHK(wake_pin, 1'h0)
    wr(A_CFG, 32'h0000_1083);
    for (int j = 0; j < 2; j++)
    begin
      wr(A_STAT, j << 12);
      data_pol_irq <= 1'h1;
      @(posedge hclk);
      data_pol_irq <= 1'h0;
      @(posedge hclk);
      `CHK(int_bit1, 1 - j)
      frame(2'h0, 4'h0, DA, PW, 0, wid(0), j);
      rchk(A_STAT, 32'h0000_0001 | (j << 12));
    end
    give_verdict();
  end
endmodule : wold_top_tb
